// file: hdl/ftpm_map.svh
/*
 Constants of the fan tachometer period meter: clock rates, timing counts
 and counter limits.
 Assumes it is included by its bare name from the design modules.
*/
`ifndef FTPM_MAP_SVH
`define FTPM_MAP_SVH

// ============================================================
// Clocks
`define FTPM_CLK_HZ        40000000
`define FTPM_REF_HZ        90000
// Reference tick divider, integer rate division
`define FTPM_REF_DIV       (`FTPM_CLK_HZ / `FTPM_REF_HZ)

// ============================================================
// Measurement interval of stretched channels
`define FTPM_MEAS_MS       1000
`define FTPM_MEAS_CYCLES   (`FTPM_MEAS_MS * (`FTPM_CLK_HZ / 1000))

// ============================================================
// Counter limits
`define FTPM_CNT_W         16
`define FTPM_CNT_MAX       16'hffff
`define FTPM_CNT_ZERO      16'h0000
// Rising edges tallied between the first and the one that closes a measurement
`define FTPM_EDGE_CLOSE    2'h1

`endif

// file: hdl/ftpm_pkg.sv
/*
 Types of the fan tachometer period meter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ftpm_pkg;

  // ============================================================
  // Per-tachometer measurement state
  typedef enum logic [1:0] {
    TS_IDLE,
    TS_WAIT_FIRST,
    TS_COUNT
  } ftpm_tach_state_t;

endpackage : ftpm_pkg

// file: hdl/ftpm_tach_chan.sv
/*
 One tachometer channel: pin synchroniser, rising edge detect, saturating
 16-bit period counter and the byte-pair read latch.
 Assumes ref_tick_in is a one-cycle pulse at the reference rate on clk_sys_in.
*/
`timescale 1ns/10ps
`include "ftpm_map.svh"

module ftpm_tach_chan (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  // Tachometer pin, asynchronous
  input  wire logic       tach_pin_in,
  // Control
  input  wire logic       ref_tick_in,
  input  wire logic       start_in,
  input  wire logic       cont_in,
  // Reading
  input  wire logic       rd_lo_in,
  input  wire logic       rd_hi_in,
  output logic            busy_out,
  output logic            done_out,
  output logic [7:0]      val_lo_out,
  output logic [7:0]      val_hi_out
);
  import ftpm_pkg::*;

  // ============================================================
  // State
  ftpm_tach_state_t       state_q;
  ftpm_tach_state_t       state_d;
  logic                   sync1_q;
  logic                   sync2_q;
  logic                   prev_q;
  logic [15:0]            cnt_q;
  logic [15:0]            cnt_d;
  logic [1:0]             edges_q;
  logic [15:0]            val_q;
  logic                   done_q;
  logic                   frozen_q;
  logic [7:0]             lo_q;
  logic [7:0]             hi_q;

  // Edge and end-of-measurement decode
  wire rise      = sync2_q & ~prev_q;
  wire at_max    = (cnt_q == `FTPM_CNT_MAX);
  wire last_edge = (state_q == TS_COUNT) & rise & (edges_q == `FTPM_EDGE_CLOSE);
  wire timeout   = (state_q != TS_IDLE) & at_max & ~last_edge;
  wire finish    = last_edge | timeout;
  wire out_hold  = frozen_q | rd_lo_in;

  // Two flops before the edge detector sees the pin
  // Reset to the pulled-up idle level, so no false edge follows reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= tach_pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Sequencing; continuous mode rearms at once
  always_comb begin
    state_d = state_q;
    case (state_q)
      TS_IDLE:       if (start_in | cont_in) state_d = TS_WAIT_FIRST;
      TS_WAIT_FIRST: begin
        if (finish) state_d = cont_in ? TS_WAIT_FIRST : TS_IDLE;
        else if (rise) state_d = TS_COUNT;
      end
      TS_COUNT:      if (finish) state_d = cont_in ? TS_WAIT_FIRST : TS_IDLE;
      default:       state_d = TS_IDLE;
    endcase
  end

  // Counter restarts per measurement and clears one cycle after reaching full scale
  always_comb begin
    cnt_d = cnt_q;
    if ((state_q == TS_IDLE) || finish) cnt_d = `FTPM_CNT_ZERO;
    else if ((state_q == TS_WAIT_FIRST) && rise) cnt_d = `FTPM_CNT_ZERO;
    else if (ref_tick_in && !at_max) cnt_d = cnt_q + 16'h0001;
  end

  // Counter, edge tally and result
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      state_q <= TS_IDLE;
      cnt_q   <= `FTPM_CNT_ZERO;
      edges_q <= 2'h0;
      val_q   <= `FTPM_CNT_MAX;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      edges_q <= (state_q != TS_COUNT) ? 2'h0 : (edges_q + {1'b0, rise});
      val_q   <= finish ? cnt_q : val_q;
      done_q  <= finish;
    end
  end

  // Low-byte read freezes both bytes until the high byte is read
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      frozen_q <= 1'b0;
      lo_q     <= 8'(`FTPM_CNT_MAX);
      hi_q     <= 8'(`FTPM_CNT_MAX >> 8);
    end else begin
      frozen_q <= rd_lo_in | (frozen_q & ~rd_hi_in);
      lo_q     <= out_hold ? lo_q : val_q[7:0];
      hi_q     <= out_hold ? hi_q : val_q[15:8];
    end
  end

  assign busy_out   = (state_q != TS_IDLE);
  assign done_out   = done_q;
  assign val_lo_out = lo_q;
  assign val_hi_out = hi_q;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  property p_sat_no_wrap;
    at_max |=> (cnt_q == `FTPM_CNT_MAX) || (cnt_q == `FTPM_CNT_ZERO);
  endproperty
  a_sat_no_wrap: assert property (p_sat_no_wrap) else $error("counter wrapped");

  property p_third_edge_store;
    last_edge |=> done_q && (val_q == $past(cnt_q));
  endproperty
  a_third_edge_store: assert property (p_third_edge_store) else $error("bad store");

  property p_stall_full;
    (state_q == TS_WAIT_FIRST) && at_max |=> done_q && (val_q == 16'hffff);
  endproperty
  a_stall_full: assert property (p_stall_full) else $error("stall not full");

  property p_hi_frozen;
    frozen_q && !rd_hi_in |=> $stable(hi_q);
  endproperty
  a_hi_frozen: assert property (p_hi_frozen) else $error("high byte moved");

  property p_rise_single;
    rise |=> !rise;
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("double edge");

  property p_cont_rearm;
    finish && cont_in |=> (state_q == TS_WAIT_FIRST);
  endproperty
  a_cont_rearm: assert property (p_cont_rearm) else $error("no rearm");

endmodule : ftpm_tach_chan

// file: hdl/ftpm_top.sv
/*
 Fan tachometer period meter: eight tachometer channels, four paired PWM
 drives with pulse stretching for chopped three-wire fans, and continuous
 measurement for four-wire or dc-driven fans.
 Assumes pwm_drive_in comes from a PWM generator on clk_sys_in, and the
 configuration inputs are held steady by software-facing logic.
*/
// Overview of operation
// - Stretch chopped three-wire drive full-on while measuring
// - Continuous fans on a pair whose inputs are both continuous measured without drive stretching
// - Gate 90 kHz reference into 16-bit counter
// - Continuous-measure bit per input disables stretching
// - High-frequency drive mode forces continuous bits set
// - Drive and tach pair share stretch state
// - PWM n pairs with tach 2n-1, 2n
// - Stretched channels measured once every second
// - Count first to third rising edge, store
// - Restore programmed duty after stretch ends
// - Low-byte read freezes high byte until read
// - All-ones reading means stalled or very slow
`timescale 1ns/10ps
`include "ftpm_map.svh"

module ftpm_top #(
  parameter int REF_DIV     = `FTPM_REF_DIV,
  parameter int MEAS_CYCLES = `FTPM_MEAS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  // Tachometer pins, asynchronous
  input  wire logic [7:0]  tach_pin_in,
  // Programmed drive and fan outputs
  input  wire logic [3:0]  pwm_drive_in,
  input  wire logic [3:0]  pwm_invert_in,
  output logic      [3:0]  pwm_out,
  // Configuration
  input  wire logic        high_freq_drive_mode_in,
  input  wire logic [7:0]  cont_cfg_in,
  output logic      [7:0]  continuous_measure_bit_out,
  // Readings, byte pair per input
  input  wire logic [7:0]  rd_lo_in,
  input  wire logic [7:0]  rd_hi_in,
  output logic      [63:0] tach_lo_out,
  output logic      [63:0] tach_hi_out,
  // Status
  output logic      [3:0]  stretch_active_out,
  output logic      [7:0]  meas_done_out
);
  import ftpm_pkg::*;

  localparam int RW = (REF_DIV > 1) ? $clog2(REF_DIV) : 1;
  localparam int SW = (MEAS_CYCLES > 1) ? $clog2(MEAS_CYCLES) : 1;
  localparam logic [RW-1:0] REF_LAST = RW'(REF_DIV - 1);
  localparam logic [SW-1:0] SEC_LAST = SW'(MEAS_CYCLES - 1);
  // Longest legal stretch: wait and count both timing out, plus tick slack
  localparam int            ST_CYC   = 2 * (`FTPM_CNT_MAX + 1) * REF_DIV + 16;
  localparam int            STW      = $clog2(ST_CYC + 1);
  localparam logic [STW-1:0] ST_LIMIT = STW'(ST_CYC);

  // ============================================================
  // Parameter checks
  // A divide of one ticks every clock, which keeps short runs short
  if (REF_DIV < 1) begin : g_chk_ref
    $error("REF_DIV must be at least 1");
  end
  if (MEAS_CYCLES < 16) begin : g_chk_meas
    $error("MEAS_CYCLES must be at least 16");
  end

  // ============================================================
  // Timebase
  logic [RW-1:0] ref_cnt_q;
  logic [SW-1:0] sec_cnt_q;
  logic          sec_tick_q;

  wire ref_tick = (ref_cnt_q == REF_LAST);
  wire sec_wrap = (sec_cnt_q == SEC_LAST);

  // Reference divider and one-second interval
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ref_cnt_q  <= '0;
      sec_cnt_q  <= '0;
      sec_tick_q <= 1'b0;
    end else begin
      ref_cnt_q  <= ref_tick ? '0 : (ref_cnt_q + RW'(1));
      sec_cnt_q  <= sec_wrap ? '0 : (sec_cnt_q + SW'(1));
      sec_tick_q <= sec_wrap;
    end
  end

  // ============================================================
  // Continuous-measure bits
  logic [7:0] cont_q;

  // High-frequency drive mode needs no stretching on any input
  wire [7:0] cont_eff = cont_cfg_in | {8{high_freq_drive_mode_in}};

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cont_q <= 8'h00;
    end else begin
      cont_q <= cont_eff;
    end
  end

  assign continuous_measure_bit_out = cont_q;

  // ============================================================
  // Tachometer channels
  logic [7:0] start;
  logic [7:0] busy;
  logic [7:0] done;

  for (genvar t = 0; t < 8; t++) begin : g_tach
    ftpm_tach_chan u_chan (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in),
      .tach_pin_in (tach_pin_in[t]),
      .ref_tick_in (ref_tick),
      .start_in    (start[t]),
      .cont_in     (cont_q[t]),
      .rd_lo_in    (rd_lo_in[t]),
      .rd_hi_in    (rd_hi_in[t]),
      .busy_out    (busy[t]),
      .done_out    (done[t]),
      .val_lo_out  (tach_lo_out[t*8 +: 8]),
      .val_hi_out  (tach_hi_out[t*8 +: 8])
    );
  end

  assign meas_done_out = done;

  // ============================================================
  // Drive pairs and pulse stretching
  logic [7:0] pend_q;
  logic [3:0] stretch_q;
  logic [3:0] pwm_q;

  for (genvar p = 0; p < 4; p++) begin : g_pair
    // Inputs 2p and 2p+1 ride on drive p
    wire [1:0] pcont = cont_q[2*p +: 2];
    wire [1:0] pbusy = busy[2*p +: 2];
    wire [1:0] pdone = done[2*p +: 2];

    // Stretched inputs start together once a second
    wire [1:0] pstart = {2{sec_tick_q & ~stretch_q[p]}} & ~pcont & ~pbusy;
    // A finishing input leaves the pending set; new start wins
    wire [1:0] pend_d = (|pstart) ? pstart : (pend_q[2*p +: 2] & ~pdone);
    wire       st_d   = |pend_d;

    assign start[2*p +: 2] = pstart;

    always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
        pend_q[2*p +: 2] <= 2'h0;
        stretch_q[p]     <= 1'b0;
        pwm_q[p]         <= 1'b0;
      end else begin
        pend_q[2*p +: 2] <= pend_d;
        stretch_q[p]     <= st_d;
        // Full-on level depends on drive polarity; else programmed duty
        pwm_q[p]         <= stretch_q[p] ? ~pwm_invert_in[p] : pwm_drive_in[p];
      end
    end

    // --------------------------------------------------------
    // Checks for this pair
    sequence s_go;
      sec_tick_q && !stretch_q[p] && (|pstart);
    endsequence

    sequence s_full_on;
      pwm_q[p] == ~$past(pwm_invert_in[p]);
    endsequence

    property p_engage;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      s_go |=> stretch_q[p] ##1 s_full_on;
    endproperty
    a_engage: assert property (p_engage) else $error("stretch not engaged");

    property p_full;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      stretch_q[p] |=> s_full_on;
    endproperty
    a_full: assert property (p_full) else $error("drive not full-on");

    property p_restore;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      $fell(stretch_q[p]) |=> (pwm_q[p] == $past(pwm_drive_in[p]));
    endproperty
    a_restore: assert property (p_restore) else $error("duty not restored");

    property p_no_stretch_cont;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      (&pcont) && !stretch_q[p] |=> !stretch_q[p];
    endproperty
    a_no_stretch_cont: assert property (p_no_stretch_cont) else $error("stretched");

    property p_sync_pair;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      stretch_q[p] |-> (|(pend_q[2*p +: 2] & (pbusy | pdone)));
    endproperty
    a_sync_pair: assert property (p_sync_pair) else $error("pair unsynced");

    property p_follow;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      !stretch_q[p] |=> (pwm_q[p] == $past(pwm_drive_in[p]));
    endproperty
    a_follow: assert property (p_follow) else $error("drive not followed");

    property p_start_on_tick;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      $rose(stretch_q[p]) |-> $past(sec_tick_q);
    endproperty
    a_start_on_tick: assert property (p_start_on_tick) else $error("stretch off tick");

    property p_hold_pend;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      stretch_q[p] && (|(pend_q[2*p +: 2] & ~pdone)) |=> stretch_q[p];
    endproperty
    a_hold_pend: assert property (p_hold_pend) else $error("stretch dropped early");

    // --------------------------------------------------------
    // Stretch length guard; a lost result would hold the fan full-on
    logic [STW-1:0] st_len_q;
    wire            st_over = (st_len_q == ST_LIMIT);

    always_ff @(posedge clk_sys_in) begin
      if (!rst_b_in) begin
        st_len_q <= '0;
      end else begin
        st_len_q <= !stretch_q[p] ? '0 : (st_over ? st_len_q : (st_len_q + STW'(1)));
      end
    end

    property p_stretch_ends;
      @(posedge clk_sys_in) disable iff (!rst_b_in)
      stretch_q[p] |-> !st_over;
    endproperty
    a_stretch_ends: assert property (p_stretch_ends) else $error("stretch never ended");
  end

  assign pwm_out            = pwm_q;
  assign stretch_active_out = stretch_q;

  // ============================================================
  // Timebase and high-frequency mode checks
  property p_ref_spacing;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    ref_tick && (REF_DIV > 1) |=> !ref_tick;
  endproperty
  a_ref_spacing: assert property (p_ref_spacing) else $error("ref tick too close");

  property p_hf_cont;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    high_freq_drive_mode_in |=> (cont_q == 8'hff);
  endproperty
  a_hf_cont: assert property (p_hf_cont) else $error("bits not forced");

  property p_sec_single;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    sec_tick_q |=> !sec_tick_q [*8];
  endproperty
  a_sec_single: assert property (p_sec_single) else $error("interval too short");

  // ============================================================
  // Start and configuration checks
  property p_cont_cfg;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !high_freq_drive_mode_in |=> (cont_q == $past(cont_cfg_in));
  endproperty
  a_cont_cfg: assert property (p_cont_cfg) else $error("bits not taken");

  property p_no_start_cont;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start & cont_q) == 8'h00;
  endproperty
  a_no_start_cont: assert property (p_no_start_cont) else $error("continuous input started");

  property p_start_idle;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (start & busy) == 8'h00;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while busy");

endmodule : ftpm_top

// file: tb/ftpm_fan_model.sv
/*
 Fan model: eight fans with tachometer lines on four paired drives.
 Assumes drive levels from the meter; half periods counted in clocks.
*/
`timescale 1ns/10ps

module ftpm_fan_model (
  // Clock
  input  wire logic       clk_sys_in,
  // Drive seen by the fans
  input  wire logic [3:0] pwm_out_in,
  input  wire logic [3:0] pwm_invert_in,
  // Fan setup
  input  wire logic [7:0] wire4_in,
  input  wire logic [7:0] spin_in,
  input  wire logic [7:0] base_in,
  // Tachometer lines, open collector with pull-up
  output logic      [7:0] tach_out = 8'hff
);
  int         cnt [8];
  logic [3:0] full_on;
  logic [7:0] powered;

  // ============================================================
  // Power per fan
  // Four-wire fans always powered; three-wire only at full-on drive
  assign full_on = pwm_out_in ^ pwm_invert_in;
  assign powered = wire4_in | {{2{full_on[3]}}, {2{full_on[2]}},
                               {2{full_on[1]}}, {2{full_on[0]}}};

  // ============================================================
  // Tachometer pulses
  // Unpowered or stalled: line released, so the pull-up wins
  always_ff @(posedge clk_sys_in) begin
    for (int t = 0; t < 8; t++) begin
      if (!(powered[t] && spin_in[t])) begin
        tach_out[t] <= 1'b1;
        cnt[t]      <= 0;
      end else if (cnt[t] >= int'(base_in) + t) begin
        tach_out[t] <= ~tach_out[t];
        cnt[t]      <= 0;
      end else begin
        cnt[t]      <= cnt[t] + 1;
      end
    end
  end
endmodule : ftpm_fan_model

// file: tb/tb.sv
/*
 Testbench of the fan tachometer period meter: stretched, continuous,
 stall and byte-pair freeze scenarios against a fan model.
 Assumes the meter under hdl/ and the fan model under tb/.
*/
`timescale 1ns/10ps

module tb;
  // ============================================================
  // Signals
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic [7:0]  tach_pin;
  logic [3:0]  pwm_drive  = 4'h0;
  logic [3:0]  pwm_invert = 4'h0;
  logic [3:0]  pwm_out;
  logic        hf_mode    = 1'b0;
  logic [7:0]  cont_cfg   = 8'h00;
  logic [7:0]  cont_bits;
  logic [7:0]  rd_lo      = 8'h00;
  logic [7:0]  rd_hi      = 8'h00;
  logic [63:0] tach_lo;
  logic [63:0] tach_hi;
  logic [3:0]  stretch;
  logic [7:0]  done;
  logic [7:0]  wire4      = 8'h00;
  logic [7:0]  spin       = 8'hff;
  logic [7:0]  base       = 8'd20;
  int          err_total  = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;

  // ============================================================
  // Clock, cycle count and instances
  // Reference tick every clock keeps the stall timeout near 65k cycles
  always #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;

  ftpm_top #(.REF_DIV(1), .MEAS_CYCLES(2000)) ftpm_top_inst (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tach_pin_in(tach_pin),
    .pwm_drive_in(pwm_drive), .pwm_invert_in(pwm_invert), .pwm_out(pwm_out),
    .high_freq_drive_mode_in(hf_mode), .cont_cfg_in(cont_cfg),
    .continuous_measure_bit_out(cont_bits), .rd_lo_in(rd_lo), .rd_hi_in(rd_hi),
    .tach_lo_out(tach_lo), .tach_hi_out(tach_hi),
    .stretch_active_out(stretch), .meas_done_out(done));

  ftpm_fan_model ftpm_fan_model_inst (
    .clk_sys_in(clk_sys_in), .pwm_out_in(pwm_out), .pwm_invert_in(pwm_invert),
    .wire4_in(wire4), .spin_in(spin), .base_in(base), .tach_out(tach_pin));

  // ============================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step

  function automatic logic [15:0] rdg(input int t);
    return {tach_hi[8*t+:8], tach_lo[8*t+:8]};
  endfunction : rdg

  // Two tach periods of ticks, two ticks slack for the synchroniser
  task automatic check_rdg(input int t);
    logic [15:0] v;
    int          e;
    v = rdg(t);
    e = 4 * (int'(base) + t + 1);
    check($sformatf("reading %0d", t), {15'h0, (v >= e - 2) && (v <= e + 2)}, 16'h1);
  endtask : check_rdg

  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic give_up();
    check("bounded wait", 16'h0, 16'h1);
    tally_and_finish();
  endtask : give_up

  task automatic wait_done(input int t, input int lim);
    int n;
    n = 0;
    do begin
      step(1);
      n++;
      if (n > lim) give_up();
    end while (done[t] !== 1'b1);
    // Bytes follow the done pulse by one clock
    step(1);
  endtask : wait_done

  task automatic wait_stretch(input logic [3:0] v, input int lim);
    int n;
    n = 0;
    do begin
      step(1);
      n++;
      if (n > lim) give_up();
    end while (stretch !== v);
  endtask : wait_stretch

  // ============================================================
  // Scenarios
  task automatic s_reset();
    check("pwm_out", {12'h0, pwm_out}, 16'h0);
    check("stretch", {12'h0, stretch}, 16'h0);
    check("cont bits", {8'h0, cont_bits}, 16'h0);
    for (int t = 0; t < 8; t++) check("reset reading", rdg(t), 16'hffff);
  endtask : s_reset

  // Chopped three-wire fans, inverted drive on pairs 0 and 2
  task automatic s_stretch();
    int         t0;
    logic [7:0] got;
    logic [7:0] due;
    pwm_invert = 4'h5;
    pwm_drive  = 4'h5;
    got        = 8'h00;
    due        = 8'h00;
    wait_stretch(4'hf, 2100);
    t0 = cyc;
    step(1);
    check("full-on drive", {12'h0, pwm_out}, 16'h000a);
    // Readings are judged one clock after done, when the bytes show them
    for (int n = 0; n < 2000 && got != 8'hff; n++) begin
      step(1);
      for (int t = 0; t < 8; t++) begin
        if (due[t]) begin
          got[t] = 1'b1;
          check_rdg(t);
        end
        due[t] = (done[t] === 1'b1);
      end
    end
    check("stretched done", {8'h0, got}, 16'h00ff);
    check("stretch end", {12'h0, stretch}, 16'h0);
    step(1);
    check("restored drive", {12'h0, pwm_out}, 16'h0005);
    wait_stretch(4'hf, 2100);
    check("interval", 16'(cyc - t0), 16'd2000);
    wait_stretch(4'h0, 2000);
  endtask : s_stretch

  // Three-wire fans on a dc drive, continuous bits set by software
  task automatic s_cont();
    logic [3:0] seen;
    logic [7:0] got;
    logic [7:0] due;
    pwm_drive = 4'ha;
    cont_cfg  = 8'hff;
    seen      = 4'h0;
    got       = 8'h00;
    due       = 8'h00;
    for (int n = 0; n < 4200; n++) begin
      step(1);
      seen |= stretch;
      for (int t = 0; t < 8; t++) begin
        if (due[t]) begin
          got[t] = 1'b1;
          check_rdg(t);
        end
        due[t] = (done[t] === 1'b1);
      end
    end
    check("cont bits", {8'h0, cont_bits}, 16'h00ff);
    check("no stretch", {12'h0, seen}, 16'h0);
    check("all measured", {8'h0, got}, 16'h00ff);
  endtask : s_cont

  task automatic s_stall();
    spin = 8'h7f;
    step(8);
    wait_done(7, 70000);
    check("stall reading", rdg(7), 16'hffff);
    spin = 8'hff;
    wait_done(7, 400);
    check_rdg(7);
  endtask : s_stall

  task automatic s_freeze();
    logic [15:0] v0;
    v0       = rdg(2);
    rd_lo[2] = 1'b1;
    step(1);
    rd_lo[2] = 1'b0;
    base     = 8'd30;
    wait_done(2, 400);
    wait_done(2, 400);
    check("frozen pair", rdg(2), v0);
    rd_hi[2] = 1'b1;
    step(1);
    rd_hi[2] = 1'b0;
    wait_done(2, 400);
    check_rdg(2);
  endtask : s_freeze

  task automatic s_hf();
    hf_mode  = 1'b1;
    cont_cfg = 8'h00;
    step(2);
    check("forced cont bits", {8'h0, cont_bits}, 16'h00ff);
    hf_mode = 1'b0;
    step(2);
    check("released cont bits", {8'h0, cont_bits}, 16'h0);
  endtask : s_hf

  // ============================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1;
    rst_b_in = 1'b1;
    step(1);
    s_reset();
    s_stretch();
    s_cont();
    s_stall();
    s_freeze();
    s_hf();
    tally_and_finish();
  end
endmodule : tb
